/* logic/option_security_pkg.sv */
// Package: constants and types for the option byte, protection and reset sequencing
package option_security_pkg;

  // ****************************************************
  // Option byte location and layout
  // ****************************************************
  localparam logic [15:0] OPT_ADDR        = 16'h3FFF;
  localparam logic [15:0] OPT_ALIAS_ADDR  = 16'hFFFF;
  localparam int          SECURE_BIT      = 5;
  localparam int          WDOG_DIS_BIT    = 2;
  localparam int          STOP_DIS_BIT    = 1;
  localparam int          BOOT_FLASH_BIT  = 0;
  localparam logic [7:0]  OPT_RESET       = 8'h00;
  localparam logic [7:0]  READ_LOCKED     = 8'hFF;
  localparam logic [7:0]  ERASED_BYTE     = 8'h00;
  localparam int          PAGE_BITS       = 6;

  // ****************************************************
  // Values loaded by reset
  // ****************************************************
  localparam logic [14:0] PC_RESET        = 15'h0000;
  localparam logic [7:0]  SP_RESET        = 8'h6F;
  localparam logic [7:0]  IDLE_TIMER_CONTROL_RESET      = 8'h40;
  localparam int          TX_BUFFER_EMPTY_FLAG_BIT        = 1;
  localparam logic [7:0]  SERIAL_IRQ_RESET = 8'h02;
  localparam logic [1:0]  WD_WINDOW_MAX   = 2'h3;
  localparam logic [15:0] IDLE_PRESET     = 16'h00F0;
  localparam logic [4:0]  CMON_RECOVER_TICKS = 5'h10;

  // ****************************************************
  // Programming port operations
  // ****************************************************
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_PAGE_ERASE,
    OP_MASS_ERASE
  } prog_op_t;

endpackage // option_security_pkg

/* logic/brownout_idle_timer.sv */
// Brownout hold and idle-timer countdown that ends the internal reset
module brownout_idle_timer
  import option_security_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Supply monitor and timer tick
  input  wire logic brownoutLow,
  input  wire logic idleTick,
  // Result
  output logic      borHold
);
  import option_security_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic        hold;
  } bor_state_t;

  bor_state_t state;
  bor_state_t next_state;

  always_comb begin
    next_state = state;
    if (brownoutLow) begin
      // Any dip restarts the whole sequence
      next_state.count = IDLE_PRESET;
      next_state.hold  = 1'b1;
    end else if (state.hold && idleTick) begin
      if (state.count == 16'h0000) begin
        next_state.hold = 1'b0;
      end else begin
        next_state.count = state.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= '{count: IDLE_PRESET, hold: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign borHold = state.hold;

endmodule // brownout_idle_timer

/* logic/option_security_reset_ctrl.sv */
// Option byte, flash protection gate and reset sequencing
// Contract
// - Option byte sits at 0x3FFF; written only in programming modes.
// - Factory-fresh option byte reads 00.
// - Bit 5 set locks flash read/write except user commands; mass erase allowed.
// - Bit 2 set disables watchdog; clear makes watchdog pin output with pull-up.
// - Bit 1 set forbids stop mode; clear permits it.
// - Bit 0 set boots from flash; clear boots from ROM loader.
// - Locked external reads return FF; option byte always readable via FFFF.
// - Lock blocks writes to flash and option byte, and page erase.
// - Mass erase always runs; only it clears lock outside user commands.
// - Reset pin low or brownout initializes; pin held one instruction cycle.
// - Ports float in reset; watchdog pin and neighbours keep exceptions.
// - Reset clears idle-timer control except fast oscillator enable set.
// - Reset loads stack pointer with 06F.
// - Warm reset keeps RAM, pointers, shift register; power-on leaves them undefined.
// - Reset clears serial registers except transmit-empty flag set.
// - Reset clears programming addresses, presets timing for 10 MHz.
// - Watchdog and clock monitor armed after reset, window maximal, inhibited during.
// - Clock monitor error drives pin low; high again 16 ticks after recovery.
// - Brownout holds reset, presets idle timer; underflow releases it.
module option_security_reset_ctrl
  import option_security_pkg::*;
#(
  parameter logic [7:0] ProgTiming10M = 8'h00
)(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Reset sources and monitors
  input  wire logic        resetPinN,
  input  wire logic        brownoutLow,
  input  wire logic        idleTick,
  input  wire logic        clockSlow,
  // Programming port
  input  wire logic        progMode,
  input  wire logic        userIspCmd,
  input  wire logic        progReq,
  input  wire option_security_pkg::prog_op_t progOp,
  input  wire logic [15:0] progAddr,
  input  wire logic [7:0]  progWdata,
  output logic             progAck,
  output logic             progDenied,
  output logic [7:0]       progRdata,
  // Flash array port
  output logic             flashReq,
  output option_security_pkg::prog_op_t flashOp,
  output logic [15:0]      flashAddr,
  output logic [7:0]       flashWdata,
  input  wire logic [7:0]  flashRdata,
  // Decoded options
  output logic [7:0]       optionConfigByte,
  output logic             securityOn,
  output logic             watchdogEnable,
  output logic             stopDisable,
  output logic             bootFromFlash,
  // Reset state
  output logic             coreResetN,
  output logic             coldStart,
  output logic [14:0]      progCounterInit,
  output logic [7:0]       stackPtrInit,
  output logic [7:0]       idleCtrlInit,
  output logic [7:0]       serialIrqInit,
  output logic [7:0]       progTimingInit,
  // Pins and watchdog
  output logic             portsHighZ,
  output logic             neighbourPullup,
  output logic             watchdogPinOut,
  output logic             watchdogPinOe,
  output logic             watchdogPullup,
  output logic             watchdogArmed,
  output logic [1:0]       watchdogWindow
);
  import option_security_pkg::*;

  typedef enum logic {ST_IDLE, ST_FLASH} access_st_t;

  typedef struct packed {
    access_st_t  acc;
    logic [7:0]  opt;
    logic        ack;
    logic        denied;
    logic [7:0]  rdata;
    logic        fReq;
    prog_op_t    fOp;
    logic [15:0] fAddr;
    logic [7:0]  fWdata;
    logic        inReset;
    logic        cold;
    logic        cmonErr;
    logic [4:0]  cmonCnt;
    logic        armed;
    logic [14:0] pcInit;
    logic [7:0]  spInit;
    logic [7:0]  itmrInit;
    logic [7:0]  serInit;
    logic [7:0]  ptimInit;
    logic [1:0]  wdWin;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic        borHold;

  function automatic logic samePage(input logic [15:0] a, input logic [15:0] b);
    return a[15:PAGE_BITS] == b[15:PAGE_BITS];
  endfunction

  // ****************************************************
  // Brownout sequencing
  // ****************************************************
  brownout_idle_timer u_bor (
    .clock       (clock),
    .nrst        (nrst),
    .brownoutLow (brownoutLow),
    .idleTick    (idleTick),
    .borHold     (borHold)
  );

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    logic lockNow;
    logic optHit;
    lockNow = 1'b0;
    optHit  = 1'b0;
    next_state = state;
    next_state.ack    = 1'b0;
    next_state.denied = 1'b0;
    next_state.fReq   = 1'b0;

    // Either source initializes; pin sampled every cycle
    // Supply dip acts at once; the timer hold then covers the countdown
    next_state.inReset = !resetPinN || borHold || brownoutLow;
    if (!next_state.inReset) begin
      next_state.cold = 1'b0;
    end

    if (next_state.inReset) begin
      next_state.pcInit   = PC_RESET;
      next_state.spInit   = SP_RESET;
      next_state.itmrInit = IDLE_TIMER_CONTROL_RESET;
      next_state.serInit  = SERIAL_IRQ_RESET;
      next_state.ptimInit = ProgTiming10M;
      next_state.wdWin    = WD_WINDOW_MAX;
    end

    // Monitor is held off in reset so the error shows only after release
    next_state.armed = !state.opt[WDOG_DIS_BIT] && !next_state.inReset;
    if (next_state.inReset || state.opt[WDOG_DIS_BIT]) begin
      next_state.cmonErr = 1'b0;
      next_state.cmonCnt = 5'h00;
    end else if (clockSlow) begin
      next_state.cmonErr = 1'b1;
      next_state.cmonCnt = 5'h00;
    end else if (state.cmonErr && idleTick) begin
      if (state.cmonCnt == CMON_RECOVER_TICKS - 5'h01) begin
        next_state.cmonErr = 1'b0;
        next_state.cmonCnt = 5'h00;
      end else begin
        next_state.cmonCnt = state.cmonCnt + 5'h01;
      end
    end

    lockNow = state.opt[SECURE_BIT] && !userIspCmd;
    optHit  = progAddr == OPT_ADDR;

    unique case (state.acc)
      ST_IDLE: begin
        if (progReq) begin
          unique case (progOp)
            OP_READ: begin
              if (optHit || progAddr == OPT_ALIAS_ADDR) begin
                next_state.ack   = 1'b1;
                next_state.rdata = state.opt;
              end else if (lockNow) begin
                next_state.ack   = 1'b1;
                next_state.rdata = READ_LOCKED;
              end else begin
                next_state.fReq  = 1'b1;
                next_state.fOp   = OP_READ;
                next_state.fAddr = progAddr;
                next_state.acc   = ST_FLASH;
              end
            end
            OP_WRITE: begin
              next_state.ack = 1'b1;
              if (optHit) begin
                if (progMode && !state.opt[SECURE_BIT]) begin
                  next_state.opt = progWdata;
                end else begin
                  next_state.denied = 1'b1;
                end
              end else if (lockNow) begin
                next_state.denied = 1'b1;
              end else begin
                next_state.fReq   = 1'b1;
                next_state.fOp    = OP_WRITE;
                next_state.fAddr  = progAddr;
                next_state.fWdata = progWdata;
              end
            end
            OP_PAGE_ERASE: begin
              next_state.ack = 1'b1;
              if (lockNow) begin
                next_state.denied = 1'b1;
              end else begin
                next_state.fReq  = 1'b1;
                next_state.fOp   = OP_PAGE_ERASE;
                next_state.fAddr = progAddr;
                if (samePage(progAddr, OPT_ADDR)) begin
                  next_state.opt = ERASED_BYTE;
                end
              end
            end
            OP_MASS_ERASE: begin
              // Always allowed; the only path that clears the lock externally
              next_state.ack   = 1'b1;
              next_state.fReq  = 1'b1;
              next_state.fOp   = OP_MASS_ERASE;
              next_state.fAddr = progAddr;
              next_state.opt   = ERASED_BYTE;
            end
          endcase
        end
      end
      ST_FLASH: begin
        // Array answers in the same cycle as its request
        next_state.ack   = 1'b1;
        next_state.rdata = flashRdata;
        next_state.acc   = ST_IDLE;
      end
    endcase
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state          <= '0;
      state.acc      <= ST_IDLE;
      state.opt      <= OPT_RESET;
      state.fOp      <= OP_READ;
      state.inReset  <= 1'b1;
      state.cold     <= 1'b1;
      state.pcInit   <= PC_RESET;
      state.spInit   <= SP_RESET;
      state.itmrInit <= IDLE_TIMER_CONTROL_RESET;
      state.serInit  <= SERIAL_IRQ_RESET;
      state.ptimInit <= ProgTiming10M;
      state.wdWin    <= WD_WINDOW_MAX;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign progAck          = state.ack;
  assign progDenied       = state.denied;
  assign progRdata        = state.rdata;
  assign flashReq         = state.fReq;
  assign flashOp          = state.fOp;
  assign flashAddr        = state.fAddr;
  assign flashWdata       = state.fWdata;
  assign optionConfigByte = state.opt;
  assign securityOn       = state.opt[SECURE_BIT];
  assign watchdogEnable   = !state.opt[WDOG_DIS_BIT];
  assign stopDisable      = state.opt[STOP_DIS_BIT];
  assign bootFromFlash    = state.opt[BOOT_FLASH_BIT];
  assign coreResetN       = !state.inReset;
  assign coldStart        = state.cold;
  assign progCounterInit  = state.pcInit;
  assign stackPtrInit     = state.spInit;
  assign idleCtrlInit     = state.itmrInit;
  assign serialIrqInit    = state.serInit;
  assign progTimingInit   = state.ptimInit;
  assign portsHighZ       = state.inReset;
  assign neighbourPullup  = state.inReset;
  assign watchdogPinOut   = !state.cmonErr;
  assign watchdogPinOe    = !state.opt[WDOG_DIS_BIT];
  assign watchdogPullup   = !state.opt[WDOG_DIS_BIT];
  assign watchdogArmed    = state.armed;
  assign watchdogWindow   = state.wdWin;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_locked_read;
    progReq && state.acc == ST_IDLE && progOp == OP_READ && state.opt[SECURE_BIT]
      && !userIspCmd && progAddr != OPT_ADDR && progAddr != OPT_ALIAS_ADDR
      |=> progAck && progRdata == 8'hFF && !flashReq;
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read not FF");

  property p_alias_read;
    progReq && state.acc == ST_IDLE && progOp == OP_READ && progAddr == 16'hFFFF
      |=> progAck && progRdata == $past(state.opt);
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("option alias read wrong");

  property p_locked_write;
    progReq && state.acc == ST_IDLE && progOp inside {OP_WRITE, OP_PAGE_ERASE}
      && state.opt[SECURE_BIT] && !userIspCmd
      |=> progDenied && !flashReq && $stable(state.opt);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write passed");

  property p_mass_erase;
    progReq && state.acc == ST_IDLE && progOp == OP_MASS_ERASE
      |=> flashReq && flashOp == OP_MASS_ERASE && optionConfigByte == 8'h00;
  endproperty
  a_mass_erase: assert property (p_mass_erase) else $error("mass erase blocked");

  property p_opt_mode;
    progReq && state.acc == ST_IDLE && progOp == OP_WRITE && progAddr == 16'h3FFF && !progMode
      |=> progDenied && $stable(optionConfigByte);
  endproperty
  a_opt_mode: assert property (p_opt_mode) else $error("option written outside mode");

  property p_pin_reset;
    !resetPinN |=> !coreResetN && stackPtrInit == 8'h6F && portsHighZ;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");

  property p_cmon_low;
    clockSlow && watchdogArmed && !brownoutLow && resetPinN
      |=> !watchdogPinOut [*2];
  endproperty
  a_cmon_low: assert property (p_cmon_low) else $error("clock error pin not low");

  property p_no_arm_in_reset;
    !coreResetN |-> !watchdogArmed && watchdogWindow == 2'h3;
  endproperty
  a_no_arm_in_reset: assert property (p_no_arm_in_reset) else $error("watchdog armed");

  property p_idle_timer_control_init;
    $fell(coreResetN) |-> idleCtrlInit == 8'h40 && progCounterInit == 15'h0000;
  endproperty
  a_idle_timer_control_init: assert property (p_idle_timer_control_init) else $error("reset values wrong");

  property p_brownout_hold;
    brownoutLow |=> !coreResetN ##1 !coreResetN;
  endproperty
  a_brownout_hold: assert property (p_brownout_hold) else $error("brownout released");

endmodule // option_security_reset_ctrl

/* sim/flash_array_model.sv */
// Flash array model on the far side of the programming gate
module flash_array_model (
  // Clock
  input  wire logic                       clock,
  // Forwarded request
  input  wire logic                       flashReq,
  input  wire option_security_pkg::prog_op_t flashOp,
  input  wire logic [15:0]                flashAddr,
  input  wire logic [7:0]                 flashWdata,
  // Read answer
  output logic [7:0]                      flashRdata
);
  import option_security_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] lastData;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    lastData = 8'h00;
  end
  // Outside the read cycle the bus shows a changing pattern, never a held value
  always_comb begin
    if (flashReq && flashOp == OP_READ) flashRdata = mem[flashAddr];
    else flashRdata = ~lastData;
  end
  always @(posedge clock) begin
    lastData <= flashRdata;
    if (flashReq) begin
      case (flashOp)
        OP_WRITE:      mem[flashAddr] <= flashWdata;
        OP_PAGE_ERASE: for (int i = 0; i < 64; i++) mem[{flashAddr[15:6], 6'(i)}] <= 8'h00;
        OP_MASS_ERASE: for (int i = 0; i < 65536; i++) mem[i] <= 8'h00;
        default:       ;
      endcase
    end
  end
endmodule // flash_array_model

/* sim/option_security_reset_ctrl_bench.sv */
// Testbench for the option byte, protection gate and reset sequencing
module option_security_reset_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import option_security_pkg::*;
  // Arbitrary preset, checked only for propagation
  localparam logic [7:0] TimingPreset = 8'h5A;
  logic clock, nrst, resetPinN, brownoutLow, idleTick, clockSlow;
  logic progMode, userIspCmd, progReq, progAck, progDenied, flashReq;
  prog_op_t progOp, flashOp;
  logic [15:0] progAddr, flashAddr;
  logic [7:0] progWdata, progRdata, flashWdata, flashRdata, optionConfigByte;
  logic securityOn, watchdogEnable, stopDisable, bootFromFlash, coreResetN, coldStart;
  logic [14:0] progCounterInit;
  logic [7:0] stackPtrInit, idleCtrlInit, serialIrqInit, progTimingInit;
  logic portsHighZ, neighbourPullup, watchdogPinOut, watchdogPinOe, watchdogPullup;
  logic watchdogArmed;
  logic [1:0] watchdogWindow;
  logic gotDenied;
  logic [7:0] gotData;
  int n_fail, total_checks, cycles;

  option_security_reset_ctrl #(.ProgTiming10M(TimingPreset)) i_option_security_reset_ctrl (
    .clock(clock), .nrst(nrst), .resetPinN(resetPinN), .brownoutLow(brownoutLow),
    .idleTick(idleTick), .clockSlow(clockSlow), .progMode(progMode),
    .userIspCmd(userIspCmd), .progReq(progReq), .progOp(progOp), .progAddr(progAddr),
    .progWdata(progWdata), .progAck(progAck), .progDenied(progDenied),
    .progRdata(progRdata), .flashReq(flashReq), .flashOp(flashOp),
    .flashAddr(flashAddr), .flashWdata(flashWdata), .flashRdata(flashRdata),
    .optionConfigByte(optionConfigByte), .securityOn(securityOn),
    .watchdogEnable(watchdogEnable), .stopDisable(stopDisable),
    .bootFromFlash(bootFromFlash), .coreResetN(coreResetN), .coldStart(coldStart),
    .progCounterInit(progCounterInit), .stackPtrInit(stackPtrInit),
    .idleCtrlInit(idleCtrlInit), .serialIrqInit(serialIrqInit),
    .progTimingInit(progTimingInit), .portsHighZ(portsHighZ),
    .neighbourPullup(neighbourPullup), .watchdogPinOut(watchdogPinOut),
    .watchdogPinOe(watchdogPinOe), .watchdogPullup(watchdogPullup),
    .watchdogArmed(watchdogArmed), .watchdogWindow(watchdogWindow));

  flash_array_model i_flash_array_model (
    .clock(clock), .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .flashRdata(flashRdata));

  // ****************************************************
  // Clock, idle tick and timeout
  // ****************************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Tick every other cycle so tick counts are not cycle counts
  initial begin
    idleTick = 1'b0;
    forever begin
      @(posedge clock);
      #1 idleTick = ~idleTick;
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One request; answer taken at the edge where progAck is high
  task automatic prog(input prog_op_t op, input logic [15:0] addr, input logic [7:0] data,
                      input logic user);
    int k;
    k = 0;
    progOp = op;
    progAddr = addr;
    progWdata = data;
    userIspCmd = user;
    progReq = 1'b1;
    @(posedge clock);
    #1 progReq = 1'b0;
    while (progAck !== 1'b1 && k < 4) begin
      @(posedge clock);
      #1 k++;
    end
    gotDenied = progDenied;
    gotData = progRdata;
    chk(progAck, 1'b1, "request answer");
    @(posedge clock);
    #1;
  endtask

  task automatic wait_run(input int limit);
    int k;
    k = 0;
    while (coreResetN !== 1'b1 && k < limit) begin
      @(posedge clock);
      #1 k++;
    end
    chk(coreResetN, 1'b1, "reset release");
  endtask

  task automatic tick_cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset_values;
    chk(optionConfigByte, 8'h00, "factory option");
    chk(progCounterInit, 15'h0000, "pc init");
    chk(stackPtrInit, 8'h6F, "sp init");
    chk(idleCtrlInit, 8'h40, "idle ctrl init");
    chk(serialIrqInit, 8'h02, "serial irq init");
    chk(progTimingInit, TimingPreset, "timing init");
    chk({portsHighZ, neighbourPullup, watchdogPinOe}, 3'h7, "pins in reset");
    chk(coldStart, 1'b1, "cold start");
    chk(watchdogArmed, 1'b0, "armed in reset");
    wait_run(1000);
    chk(coldStart, 1'b0, "warm after release");
    chk({watchdogArmed, watchdogWindow}, 3'h7, "armed max window");
    chk(portsHighZ, 1'b0, "ports released");
  endtask

  task automatic t_option_write;
    progMode = 1'b0;
    prog(OP_WRITE, 16'h3FFF, 8'h07, 1'b0);
    chk(optionConfigByte, 8'h00, "option outside prog mode");
    progMode = 1'b1;
    prog(OP_WRITE, 16'h3FFF, 8'h07, 1'b0);
    chk(optionConfigByte, 8'h07, "option written");
    chk({watchdogEnable, watchdogPinOe, watchdogPullup}, 3'h0, "watchdog off");
    chk(stopDisable, 1'b1, "stop disabled");
    chk(bootFromFlash, 1'b1, "boot flash");
    chk(securityOn, 1'b0, "unlocked");
    prog(OP_WRITE, 16'h0010, 8'hA5, 1'b0);
    chk(gotDenied, 1'b0, "unlocked write");
    prog(OP_READ, 16'h0010, 8'h00, 1'b0);
    chk(gotData, 8'hA5, "unlocked read");
  endtask

  task automatic t_lock;
    prog(OP_PAGE_ERASE, 16'h3FC0, 8'h00, 1'b0);
    chk(optionConfigByte, 8'h00, "last page erase");
    prog(OP_WRITE, 16'h3FFF, 8'h21, 1'b0);
    chk({securityOn, bootFromFlash}, 2'h3, "locked option");
    prog(OP_READ, 16'h0010, 8'h00, 1'b0);
    chk(gotData, 8'hFF, "locked read");
    prog(OP_READ, 16'hFFFF, 8'h00, 1'b0);
    chk(gotData, 8'h21, "option alias");
    prog(OP_WRITE, 16'h0010, 8'h3C, 1'b0);
    chk(gotDenied, 1'b1, "locked write");
    prog(OP_PAGE_ERASE, 16'h0000, 8'h00, 1'b0);
    chk(gotDenied, 1'b1, "locked page erase");
    prog(OP_WRITE, 16'h3FFF, 8'h00, 1'b0);
    chk({gotDenied, optionConfigByte}, 9'h121, "locked option write");
    prog(OP_WRITE, 16'h0020, 8'h3C, 1'b1);
    chk(gotDenied, 1'b0, "user command write");
    prog(OP_MASS_ERASE, 16'h0000, 8'h00, 1'b0);
    chk({securityOn, optionConfigByte}, 9'h000, "mass erase");
    prog(OP_READ, 16'h0010, 8'h00, 1'b0);
    chk(gotData, 8'h00, "erased read");
  endtask

  task automatic t_clock_monitor;
    clockSlow = 1'b1;
    tick_cycles(1);
    chk(watchdogPinOut, 1'b0, "clock error low");
    tick_cycles(5);
    clockSlow = 1'b0;
    tick_cycles(20);
    chk(watchdogPinOut, 1'b0, "still low before 16 ticks");
    tick_cycles(20);
    chk(watchdogPinOut, 1'b1, "pin back high");
  endtask

  task automatic t_pin_reset;
    resetPinN = 1'b0;
    tick_cycles(1);
    chk({coreResetN, portsHighZ}, 2'h1, "pin reset");
    resetPinN = 1'b1;
    tick_cycles(2);
    chk({coreResetN, coldStart}, 2'h2, "warm release");
  endtask

  task automatic t_brownout;
    brownoutLow = 1'b1;
    tick_cycles(3);
    chk(coreResetN, 1'b0, "brownout hold");
    brownoutLow = 1'b0;
    tick_cycles(100);
    chk(coreResetN, 1'b0, "countdown running");
    wait_run(1000);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {nrst, brownoutLow, clockSlow, progMode, userIspCmd, progReq} = 6'h00;
    resetPinN = 1'b1;
    progOp = OP_READ;
    progAddr = 16'h0000;
    progWdata = 8'h00;
    repeat (6) @(posedge clock);
    #1 nrst = 1'b1;
    t_reset_values();
    t_option_write();
    t_lock();
    t_clock_monitor();
    t_pin_reset();
    t_brownout();
    summarize();
  end
endmodule // option_security_reset_ctrl_bench
